// *** hdl/tic_channel.sv ***
// one temperature input channel: type, unit, limits, bias, filter and APB registers
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module tic_channel #(
    parameter int TENTH_CYCLES = tic_pkg::FILT_STEP_NS / tic_pkg::CLK_PERIOD_NS
) (
    input  wire logic                pclk,            // 200 MHz clock
    input  wire logic                presetn,         // async reset, low
    input  wire logic                psel,            // apb select
    input  wire logic                penable,         // apb enable
    input  wire logic                pwrite,          // apb direction
    input  wire logic [7:0]          paddr,           // apb byte address
    input  wire logic [31:0]         pwdata,          // apb write data
    output logic [31:0]              prdata,          // apb read data
    output logic                     pready,          // apb ready
    output logic                     pslverr,         // apb error
    input  wire logic                sample_valid,    // converter sample strobe
    input  wire tic_pkg::tic_sample_s sample,         // converter sample
    input  wire logic                retain_valid,    // saved state present
    input  wire tic_pkg::tic_retain_s retain_in,      // saved state
    output tic_pkg::tic_retain_s     retain_out,      // state to save
    output tic_pkg::tic_temp_t       present_value,   // filtered value
    output tic_pkg::tic_temp_t       setting_value,   // active setpoint
    output logic                     over_range_flag, // above range
    output logic                     under_range_flag,// below range
    output logic                     open_flag,       // no sensor
    output logic                     irq              // level interrupt
);
    function automatic logic is_tenth(input logic [4:0] code);
        is_tenth = (code == 5'h01) || (code == 5'h03) || (code == 5'h05) || (code == 5'h07) ||
                   (code == 5'h0f) || (code == 5'h11) || (code == 5'h14) || (code == 5'h16);
    endfunction

    function automatic tic_pkg::tic_range_s range_of(input logic [4:0] code, input logic fahr);
        int lo;
        int hi;
        int sc;
        lo = -200;
        hi = 1350;
        case (code)
            5'h02, 5'h03, 5'h04, 5'h05: hi = 800;
            5'h06, 5'h07, 5'h10, 5'h11: hi = 400;
            5'h08: begin lo = 0; hi = 1800; end
            5'h09, 5'h0a: begin lo = 0; hi = 1750; end
            5'h0b: hi = 1300;
            5'h0c, 5'h0d: begin lo = 0; hi = 2300; end
            5'h0e, 5'h0f: hi = 900;
            5'h12: begin lo = 0; hi = 1400; end
            5'h13, 5'h14, 5'h15, 5'h16: hi = 600;
            default: hi = 1350;
        endcase
        sc = is_tenth(code) ? 10 : 1;
        lo = lo * sc;
        hi = hi * sc;
        if (fahr)
        begin
            lo = lo * 9 / 5 + 32 * sc;
            hi = hi * 9 / 5 + 32 * sc;
        end
        range_of.min = 18'(lo);
        range_of.max = 18'(hi);
    endfunction

    function automatic tic_pkg::tic_temp_t init_of(input tic_pkg::tic_range_s r);
        init_of = (r.min > 18'sh00000) ? r.min : 18'sh00000;
    endfunction

    // apb handshake: one wait cycle, answer registered
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic [31:0] rd_d;
    logic        err_d;
    wire         acc   = psel && penable;
    wire         wr_en = acc && pready_q && pwrite && !pslverr_q;
    wire tic_pkg::tic_temp_t wval = tic_pkg::tic_temp_t'(pwdata[17:0]);

    // configuration state
    tic_pkg::tic_retain_s retain_q;
    logic [4:0]         type_q;
    logic               unit_q;
    tic_pkg::tic_temp_t sv_q, hi_q, lo_q, bias_q, pv_q;
    tic_pkg::tic_temp_t sp_q [4];
    logic [1:0]         sel_q;
    logic [10:0]        filt_q;
    logic [tic_pkg::IRQ_W-1:0] ist_q, imsk_q;
    logic               over_q, under_q, open_q, irq_q, restored_q;

    wire tic_pkg::tic_range_s rng = range_of(type_q, unit_q);
    wire sel_type   = (paddr == tic_pkg::OFS_TYPE);
    wire sel_unit   = (paddr == tic_pkg::OFS_UNIT);
    wire sel_sp     = (paddr >= tic_pkg::OFS_SP0) && (paddr < tic_pkg::OFS_BIAS) && (paddr[1:0] == 2'b00);
    wire [1:0] sp_ix = 2'(paddr[3:2] - tic_pkg::OFS_SP0[3:2]);
    wire type_ok    = (pwdata[31:5] == 27'h0) && (pwdata[4:0] <= tic_pkg::TYPE_MAX);
    wire unit_ok    = (pwdata[31:1] == 31'h0);
    wire do_type    = wr_en && sel_type && type_ok && (pwdata[4:0] != type_q);
    wire do_unit    = wr_en && sel_unit && unit_ok && (pwdata[0] != unit_q);
    wire do_reinit  = do_type || do_unit;
    wire tic_pkg::tic_range_s rng_new = range_of(do_type ? pwdata[4:0] : type_q,
                                                 do_unit ? pwdata[0] : unit_q);
    wire tic_pkg::tic_temp_t init_v = init_of(rng_new);
    wire in_sv_win  = (wval >= lo_q) && (wval <= hi_q) && (wval >= rng.min) && (wval <= rng.max);
    wire hi_ok      = (wval <= rng.max) && (wval > lo_q);
    wire lo_ok      = (wval >= rng.min) && (wval < hi_q);
    wire tic_pkg::tic_temp_t blim = is_tenth(type_q) ? tic_pkg::BIAS_LIM_TNTH : tic_pkg::BIAS_LIM_INT;
    wire bias_ok    = (wval >= -blim) && (wval <= blim);
    wire filt_ok    = (pwdata[31:11] == 21'h0) && (pwdata[10:0] >= tic_pkg::FILT_MIN) &&
                      (pwdata[10:0] <= tic_pkg::FILT_MAX);

    // writes that break a range are refused and flagged
    logic reject;
    always_comb
    begin
        reject = 1'b0;
        if (wr_en)
        begin
            if (sel_type)                              reject = !type_ok;
            else if (sel_unit)                         reject = !unit_ok;
            else if (paddr == tic_pkg::OFS_SV || sel_sp) reject = !in_sv_win;
            else if (paddr == tic_pkg::OFS_SV_HI)      reject = !hi_ok;
            else if (paddr == tic_pkg::OFS_SV_LO)      reject = !lo_ok;
            else if (paddr == tic_pkg::OFS_BIAS)       reject = !bias_ok;
            else if (paddr == tic_pkg::OFS_FILT)       reject = !filt_ok;
            else if (paddr == tic_pkg::OFS_SEL)        reject = (pwdata[31:2] != 30'h0);
        end
    end
    wire wr_ok = wr_en && !reject;

    // read mux and decode
    always_comb
    begin
        rd_d  = 32'h0;
        err_d = 1'b0;
        case (paddr)
            tic_pkg::OFS_MODE:    rd_d = {29'h0, retain_q.onoff, retain_q.stop, retain_q.manual};
            tic_pkg::OFS_TYPE:    rd_d = {27'h0, type_q};
            tic_pkg::OFS_UNIT:    rd_d = {31'h0, unit_q};
            tic_pkg::OFS_SV:      rd_d = 32'(sv_q);
            tic_pkg::OFS_SV_HI:   rd_d = 32'(hi_q);
            tic_pkg::OFS_SV_LO:   rd_d = 32'(lo_q);
            tic_pkg::OFS_SEL:     rd_d = {30'h0, sel_q};
            tic_pkg::OFS_BIAS:    rd_d = 32'(bias_q);
            tic_pkg::OFS_FILT:    rd_d = {21'h0, filt_q};
            tic_pkg::OFS_PRE_MV:  rd_d = {16'h0, retain_q.preset_mv};
            tic_pkg::OFS_STOP_MV: rd_d = {16'h0, retain_q.stop_mv};
            tic_pkg::OFS_ERR_MV:  rd_d = {16'h0, retain_q.err_mv};
            tic_pkg::OFS_PV:      rd_d = 32'(pv_q);
            tic_pkg::OFS_STATUS:  rd_d = {29'h0, open_q, under_q, over_q};
            tic_pkg::OFS_IRQ_ST:  rd_d = {27'h0, ist_q};
            tic_pkg::OFS_IRQ_MSK: rd_d = {27'h0, imsk_q};
            default:
            begin
                if (sel_sp) rd_d = 32'(sp_q[sp_ix]);
                else        err_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= acc && !pready_q;
            prdata_q  <= (acc && !pready_q && !pwrite) ? rd_d : 32'h0;
            pslverr_q <= acc && !pready_q && err_d;
        end
    end

    // mode and output values: factory defaults, then saved state after release
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            retain_q   <= '{manual: 1'b0, stop: 1'b0, onoff: 1'b0, preset_mv: tic_pkg::MV_RST,
                            stop_mv: tic_pkg::MV_RST, err_mv: tic_pkg::MV_RST};
            restored_q <= 1'b0;
        end
        else if (!restored_q)
        begin
            restored_q <= 1'b1;
            if (retain_valid) retain_q <= retain_in;
        end
        else if (wr_ok)
        begin
            case (paddr)
                tic_pkg::OFS_MODE:
                begin
                    retain_q.manual <= pwdata[tic_pkg::MODE_MANUAL];
                    retain_q.stop   <= pwdata[tic_pkg::MODE_STOP];
                    retain_q.onoff  <= pwdata[tic_pkg::MODE_ONOFF];
                end
                tic_pkg::OFS_PRE_MV:  retain_q.preset_mv <= pwdata[15:0];
                tic_pkg::OFS_STOP_MV: retain_q.stop_mv   <= pwdata[15:0];
                tic_pkg::OFS_ERR_MV:  retain_q.err_mv    <= pwdata[15:0];
                default:              retain_q <= retain_q;
            endcase
        end
    end

    // channel configuration
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            type_q <= tic_pkg::TYPE_RST;
            unit_q <= 1'b0;
            sv_q   <= 18'sh00000;
            hi_q   <= tic_pkg::SV_HI_RST;
            lo_q   <= tic_pkg::SV_LO_RST;
            bias_q <= 18'sh00000;
            sel_q  <= 2'b00;
            filt_q <= tic_pkg::FILT_RST;
            imsk_q <= '0;
            for (int i = 0; i < 4; i++) sp_q[i] <= 18'sh00000;
        end
        else if (do_reinit)
        begin
            if (do_type) type_q <= pwdata[4:0];
            if (do_unit) unit_q <= pwdata[0];
            hi_q   <= rng_new.max;
            lo_q   <= rng_new.min;
            sv_q   <= init_v;
            bias_q <= 18'sh00000;
            sel_q  <= 2'b00;
            for (int i = 0; i < 4; i++) sp_q[i] <= init_v;
        end
        else if (wr_ok)
        begin
            case (paddr)
                tic_pkg::OFS_SV:      sv_q   <= wval;
                tic_pkg::OFS_SV_HI:   hi_q   <= wval;
                tic_pkg::OFS_SV_LO:   lo_q   <= wval;
                tic_pkg::OFS_SEL:     sel_q  <= pwdata[1:0];
                tic_pkg::OFS_BIAS:    bias_q <= wval;
                tic_pkg::OFS_FILT:    filt_q <= pwdata[10:0];
                tic_pkg::OFS_IRQ_MSK: imsk_q <= pwdata[tic_pkg::IRQ_W-1:0];
                default:              if (sel_sp) sp_q[sp_ix] <= wval;
            endcase
        end
    end

    // biased sample and range checks
    wire signed [18:0] biased = 19'(sample.raw) + 19'(bias_q);
    wire s_over  = !sample.open && (biased > 19'(rng.max));
    wire s_under = !sample.open && (biased < 19'(rng.min));

    // window timing in tenths of a second
    logic [24:0]  tick_cnt_q;
    logic [10:0]  win_cnt_q;
    logic signed [39:0] sum_q;
    logic [31:0]  n_q;
    wire tick    = (tick_cnt_q == 25'(TENTH_CYCLES - 1));
    wire win_end = tick && (win_cnt_q >= filt_q - 11'h001);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_q <= '0;
            win_cnt_q  <= '0;
            sum_q      <= '0;
            n_q        <= '0;
        end
        else
        begin
            tick_cnt_q <= tick ? 25'h0 : tick_cnt_q + 25'h1;
            if (tick) win_cnt_q <= win_end ? 11'h0 : win_cnt_q + 11'h1;
            if (win_end || do_reinit)
            begin
                sum_q <= '0;
                n_q   <= '0;
            end
            else if (sample_valid && !sample.open)
            begin
                sum_q <= sum_q + 40'(biased);
                n_q   <= n_q + 32'h1;
            end
        end
    end

    // serial divider: window sum over sample count
    tic_pkg::tic_div_e div_st_q;
    logic [39:0] dvd_q, quo_q;
    logic [40:0] rem_q;
    logic [31:0] dvs_q;
    logic        neg_q;
    logic [5:0]  step_q;
    logic        pv_new;
    wire  [40:0] rem_sh = {rem_q[39:0], dvd_q[39]};
    wire         ge     = rem_sh >= 41'(dvs_q);
    wire  [39:0] quo_nx = {quo_q[38:0], ge};
    wire  [39:0] quo_sg = neg_q ? 40'(-quo_nx) : quo_nx;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_st_q <= tic_pkg::DIV_IDLE;
            dvd_q    <= '0;
            quo_q    <= '0;
            rem_q    <= '0;
            dvs_q    <= '0;
            neg_q    <= 1'b0;
            step_q   <= '0;
            pv_q     <= 18'sh00000;
            pv_new   <= 1'b0;
        end
        else
        begin
            pv_new <= 1'b0;
            case (div_st_q)
                tic_pkg::DIV_IDLE:
                begin
                    if (win_end && n_q != 32'h0)
                    begin
                        div_st_q <= tic_pkg::DIV_RUN;
                        neg_q    <= sum_q[39];
                        dvd_q    <= sum_q[39] ? 40'(-sum_q) : sum_q;
                        dvs_q    <= n_q;
                        rem_q    <= '0;
                        quo_q    <= '0;
                        step_q   <= '0;
                    end
                end
                tic_pkg::DIV_RUN:
                begin
                    rem_q  <= ge ? rem_sh - 41'(dvs_q) : rem_sh;
                    dvd_q  <= {dvd_q[38:0], 1'b0};
                    quo_q  <= quo_nx;
                    step_q <= step_q + 6'h1;
                    if (step_q == 6'(tic_pkg::DIV_STEPS - 1))
                    begin
                        div_st_q <= tic_pkg::DIV_IDLE;
                        pv_q     <= quo_sg[17:0];
                        pv_new   <= 1'b1;
                    end
                end
                default: div_st_q <= tic_pkg::DIV_IDLE;
            endcase
        end
    end

    // live flags, sticky events, interrupt
    wire [tic_pkg::IRQ_W-1:0] ev = {pv_new, reject, sample_valid && sample.open && !open_q,
                                    sample_valid && s_under && !under_q, sample_valid && s_over && !over_q};
    wire [tic_pkg::IRQ_W-1:0] clr = (wr_en && paddr == tic_pkg::OFS_IRQ_ST) ?
                                    pwdata[tic_pkg::IRQ_W-1:0] : '0;
    wire [tic_pkg::IRQ_W-1:0] ist_d = (ist_q & ~clr) | ev;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            over_q  <= 1'b0;
            under_q <= 1'b0;
            open_q  <= 1'b0;
            ist_q   <= '0;
            irq_q   <= 1'b0;
        end
        else
        begin
            if (sample_valid)
            begin
                over_q  <= s_over;
                under_q <= s_under;
                open_q  <= sample.open;
            end
            ist_q <= ist_d;
            irq_q <= |(ist_d & imsk_q);
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign retain_out       = retain_q;
    assign present_value    = pv_q;
    assign setting_value    = sv_q;
    assign over_range_flag  = over_q;
    assign under_range_flag = under_q;
    assign open_flag        = open_q;
    assign irq              = irq_q;
endmodule

// *** inc/tic_pkg.sv ***
// shared constants and types of the temperature input channel
package tic_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE    = 8'h00;
    localparam logic [7:0] OFS_TYPE    = 8'h04;
    localparam logic [7:0] OFS_UNIT    = 8'h08;
    localparam logic [7:0] OFS_SV      = 8'h0c;
    localparam logic [7:0] OFS_SV_HI   = 8'h10;
    localparam logic [7:0] OFS_SV_LO   = 8'h14;
    localparam logic [7:0] OFS_SEL     = 8'h18;
    localparam logic [7:0] OFS_SP0     = 8'h1c;
    localparam logic [7:0] OFS_BIAS    = 8'h2c;
    localparam logic [7:0] OFS_FILT    = 8'h30;
    localparam logic [7:0] OFS_PRE_MV  = 8'h34;
    localparam logic [7:0] OFS_STOP_MV = 8'h38;
    localparam logic [7:0] OFS_ERR_MV  = 8'h3c;
    localparam logic [7:0] OFS_PV      = 8'h40;
    localparam logic [7:0] OFS_STATUS  = 8'h44;
    localparam logic [7:0] OFS_IRQ_ST  = 8'h48;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h4c;
    // mode register fields
    localparam int MODE_MANUAL = 0;
    localparam int MODE_STOP   = 1;
    localparam int MODE_ONOFF  = 2;
    // interrupt status fields
    localparam int IRQ_OVER   = 0;
    localparam int IRQ_UNDER  = 1;
    localparam int IRQ_OPEN   = 2;
    localparam int IRQ_REJECT = 3;
    localparam int IRQ_PV     = 4;
    localparam int IRQ_W      = 5;
    // value limits and reset values
    localparam logic [4:0]         TYPE_MAX      = 5'h16;
    localparam logic [4:0]         TYPE_RST      = 5'h00;
    localparam logic signed [17:0] BIAS_LIM_INT  = 18'sh003e7;
    localparam logic signed [17:0] BIAS_LIM_TNTH = 18'sh0270f;
    localparam logic [10:0]        FILT_MIN      = 11'h001;
    localparam logic [10:0]        FILT_MAX      = 11'h4b0;
    localparam logic [10:0]        FILT_RST      = 11'h001;
    localparam logic [15:0]        MV_RST        = 16'h0000;
    localparam logic signed [17:0] SV_HI_RST     = 18'sh00546;
    localparam logic signed [17:0] SV_LO_RST     = -18'sh000c8;
    // filter step of one tenth of a second
    localparam int CLK_PERIOD_NS = 5;
    localparam int FILT_STEP_NS  = 100_000_000;
    localparam int DIV_STEPS     = 40;

    typedef logic signed [17:0] tic_temp_t;

    typedef struct packed {
        logic      open;
        tic_temp_t raw;
    } tic_sample_s;

    typedef struct packed {
        logic        manual;
        logic        stop;
        logic        onoff;
        logic [15:0] preset_mv;
        logic [15:0] stop_mv;
        logic [15:0] err_mv;
    } tic_retain_s;

    typedef struct packed {
        tic_temp_t min;
        tic_temp_t max;
    } tic_range_s;

    typedef enum logic {DIV_IDLE, DIV_RUN} tic_div_e;
endpackage

// *** tb/tic_assertions.sv ***
// concurrent checks on the channel's ports
`timescale 1ns/1ps
module tic_assertions (
    input wire logic                 pclk,             // clock
    input wire logic                 presetn,          // async reset, low
    input wire logic                 psel,             // apb select
    input wire logic                 penable,          // apb enable
    input wire logic [31:0]          prdata,           // apb read data
    input wire logic                 pready,           // apb ready
    input wire logic                 pslverr,          // apb error
    input wire logic                 sample_valid,     // sample strobe
    input wire tic_pkg::tic_sample_s sample,           // sample
    input wire logic                 retain_valid,     // saved state present
    input wire tic_pkg::tic_retain_s retain_in,        // saved state
    input wire tic_pkg::tic_retain_s retain_out,       // state to save
    input wire logic                 over_range_flag,  // above range
    input wire logic                 under_range_flag, // below range
    input wire logic                 open_flag         // no sensor
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_retain_load;
        presetn && !$past(presetn) && retain_valid |=> retain_out == $past(retain_in);
    endproperty
    a_retain_load: assert property (p_retain_load) else $error("saved state not restored");
    property p_open_set;
        sample_valid && sample.open |=> open_flag;
    endproperty
    a_open_set: assert property (p_open_set) else $error("open sample not flagged");
    property p_open_clr;
        sample_valid && !sample.open |=> !open_flag;
    endproperty
    a_open_clr: assert property (p_open_clr) else $error("open flag stuck");
    property p_range_excl;
        !(over_range_flag && under_range_flag);
    endproperty
    a_range_excl: assert property (p_range_excl) else $error("over and under together");
    property p_flags_hold;
        !sample_valid |=> $stable({over_range_flag, under_range_flag, open_flag});
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved without sample");
    property p_ready_wait;
        psel && penable && !$past(penable) |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready late");
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    property p_err_zero;
        pslverr |-> pready && prdata == 32'h0;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("error answer malformed");
    property p_idle_zero;
        !pready |-> prdata == 32'h0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data outside answer");
endmodule
bind tic_channel tic_assertions tic_assertions_inst (.pclk, .presetn, .psel, .penable, .prdata, .pready,
    .pslverr, .sample_valid, .sample, .retain_valid, .retain_in, .retain_out, .over_range_flag,
    .under_range_flag, .open_flag);

// *** tb/tic_sensor_model.sv ***
// converter model: one sample every other cycle while enabled
`timescale 1ns/1ps
module tic_sensor_model (
    input wire logic                  pclk,         // clock
    input wire logic                  presetn,      // async reset, low
    input wire logic                  en,           // produce samples
    input wire logic                  open_i,       // sensor missing
    input wire tic_pkg::tic_temp_t    raw_i,        // reading to send
    output tic_pkg::tic_sample_s      sample,       // sample
    output logic                      sample_valid  // sample strobe
);
    wire logic send = en && !sample_valid;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_valid <= 1'b0;
            sample       <= '0;
        end
        else
        begin
            sample_valid <= send;
            // junk between samples so stale data is never trusted
            sample       <= send ? {open_i, raw_i} : ~sample;
        end
    end
endmodule

// *** tb/tic_channel_test.sv ***
// register and sensor tests of the temperature input channel
`timescale 1ns/1ps
module tic_channel_test;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, rdat;
    logic                 sample_valid, retain_valid, rerr, sen_en, sen_open;
    logic                 over_range_flag, under_range_flag, open_flag;
    tic_pkg::tic_sample_s sample;
    tic_pkg::tic_retain_s retain_in, retain_out;
    tic_pkg::tic_temp_t   present_value, setting_value, sen_raw;
    int                   miscompares, checks_done;

    tic_channel #(.TENTH_CYCLES(10)) tic_channel_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .sample_valid, .sample, .retain_valid, .retain_in, .retain_out,
        .present_value, .setting_value, .over_range_flag, .under_range_flag, .open_flag, .irq);
    tic_sensor_model tic_sensor_model_inst (.pclk, .presetn, .en(sen_en), .open_i(sen_open), .raw_i(sen_raw),
        .sample, .sample_valid);

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            miscompares++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask

    initial
    begin
        #100000;
        miscompares++;
        print_verdict();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, sen_en, sen_open, sen_raw} = '0;
        presetn      = 1'b0;
        retain_valid = 1'b1;
        retain_in    = {3'h7, 16'h0123, 16'h0456, 16'h0789};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(tic_pkg::OFS_MODE, 32'h7);
        rd(tic_pkg::OFS_PRE_MV, 32'h123);
        rd(tic_pkg::OFS_STOP_MV, 32'h456);
        rd(tic_pkg::OFS_ERR_MV, 32'h789);
        rd(tic_pkg::OFS_TYPE, 32'h0);
        rd(tic_pkg::OFS_SV_HI, 32'h546);
        rd(tic_pkg::OFS_SV_LO, 32'hffffff38);
        rd(tic_pkg::OFS_UNIT, 32'h0);
        rd(tic_pkg::OFS_BIAS, 32'h0);
        rd(tic_pkg::OFS_FILT, 32'h1);
        rd(8'h50, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        wr(tic_pkg::OFS_IRQ_MSK, 32'h8);
        wr(tic_pkg::OFS_SV, 32'h547);
        rd(tic_pkg::OFS_SV, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rd(tic_pkg::OFS_IRQ_ST, 32'h8);
        wr(tic_pkg::OFS_IRQ_ST, 32'h8);
        rd(tic_pkg::OFS_IRQ_ST, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(tic_pkg::OFS_SV, 32'h546);
        rd(tic_pkg::OFS_SV, 32'h546);
        chk({{14{setting_value[17]}}, setting_value}, 32'h546);
        wr(tic_pkg::OFS_SV_HI, 32'h547);
        rd(tic_pkg::OFS_SV_HI, 32'h546);
        wr(tic_pkg::OFS_SV_LO, 32'h546);
        rd(tic_pkg::OFS_SV_LO, 32'hffffff38);
        wr(tic_pkg::OFS_SV_LO, 32'h545);
        rd(tic_pkg::OFS_SV_LO, 32'h545);
        wr(tic_pkg::OFS_SP0 + 8'h08, 32'h546);
        rd(tic_pkg::OFS_SP0 + 8'h08, 32'h546);
        wr(tic_pkg::OFS_SP0 + 8'h08, 32'h544);
        rd(tic_pkg::OFS_SP0 + 8'h08, 32'h546);
        wr(tic_pkg::OFS_BIAS, 32'h5);
        wr(tic_pkg::OFS_SEL, 32'h1);
        wr(tic_pkg::OFS_TYPE, 32'h17);
        rd(tic_pkg::OFS_TYPE, 32'h0);
        wr(tic_pkg::OFS_TYPE, 32'h2);
        rd(tic_pkg::OFS_SV_HI, 32'h320);
        rd(tic_pkg::OFS_SV_LO, 32'hffffff38);
        rd(tic_pkg::OFS_SV, 32'h0);
        rd(tic_pkg::OFS_SEL, 32'h0);
        rd(tic_pkg::OFS_BIAS, 32'h0);
        rd(tic_pkg::OFS_SP0 + 8'h08, 32'h0);
        rd(tic_pkg::OFS_UNIT, 32'h0);
        wr(tic_pkg::OFS_UNIT, 32'h2);
        rd(tic_pkg::OFS_UNIT, 32'h0);
        wr(tic_pkg::OFS_UNIT, 32'h1);
        rd(tic_pkg::OFS_SV_HI, 32'h5c0);
        rd(tic_pkg::OFS_SV_LO, 32'hfffffeb8);
        rd(tic_pkg::OFS_TYPE, 32'h2);
        wr(tic_pkg::OFS_BIAS, 32'h3e8);
        rd(tic_pkg::OFS_BIAS, 32'h0);
        wr(tic_pkg::OFS_BIAS, 32'h3e7);
        rd(tic_pkg::OFS_BIAS, 32'h3e7);
        wr(tic_pkg::OFS_FILT, 32'h0);
        rd(tic_pkg::OFS_FILT, 32'h1);
        wr(tic_pkg::OFS_IRQ_ST, 32'h1f);
        sen_raw <= 18'sd500;
        sen_en  <= 1'b1;
        repeat (8) @(posedge pclk);
        chk({31'h0, over_range_flag}, 32'h1);
        rd(tic_pkg::OFS_STATUS, 32'h1);
        rd(tic_pkg::OFS_IRQ_ST, 32'h1);
        chk({31'h0, irq}, 32'h0);
        sen_raw <= -18'sd1400;
        repeat (8) @(posedge pclk);
        chk({31'h0, under_range_flag}, 32'h1);
        sen_raw <= 18'sd100;
        repeat (150) @(posedge pclk);
        chk({{14{present_value[17]}}, present_value}, 32'd1099);
        chk({29'h0, over_range_flag, under_range_flag, open_flag}, 32'h0);
        sen_open <= 1'b1;
        repeat (8) @(posedge pclk);
        chk({31'h0, open_flag}, 32'h1);
        print_verdict();
    end
endmodule
